// file: hw/timer_pkg.sv
// Constants shared by the sixteen-bit multimode timer and its helpers.
// Assumes the core presents byte addresses of the data space.
package timer_pkg;
  localparam int COUNT_W = 16;
  localparam int BYTE_W = 8;
  // Byte addresses of the timer registers in data space
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'hAA;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hAB;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hAC;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hAD;
  localparam logic [7:0] ADDR_CONTROL = 8'hAE;
  // Control register field positions
  localparam int MODE_SELECT_HIGH = 7;
  localparam int MODE_SELECT_MID = 6;
  localparam int MODE_SELECT_LOW = 5;
  localparam int RUN_BIT = 4;
  localparam int IRQ_PENDING_FLAG = 3;
  localparam int IRQ_ENABLE_BIT = 2;
  localparam int CAPTURE_TYPE_BIT = 1;
  localparam int RESERVED_BIT = 0;
  // Reset values
  localparam logic [15:0] COUNT_RESET = 16'hFFFF;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] ALL_ONES = 16'hFFFF;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  // Operating mode, from the two upper mode select bits {high, mid}
  typedef enum logic [1:0] {
    MODE_EVENT = 2'h0,
    MODE_CAPTURE = 2'h1,
    MODE_PWM = 2'h2,
    MODE_DIFF = 2'h3
  } mode_t;
endpackage

// file: hw/count_if.sv
// Carrier between the timer top and its down counter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface count_if #(parameter int WIDTH = 16);
  logic load;
  logic [WIDTH-1:0] load_value;
  logic step;
  logic [WIDTH-1:0] reload_value;
  logic [WIDTH-1:0] value;
  logic underflow;
  modport ctl (output load, output load_value, output step, output reload_value,
               input value, input underflow);
  modport cnt (input load, input load_value, input step, input reload_value,
               output value, output underflow);
endinterface

// file: hw/edge_sense.sv
// Rising and falling edge detector for the timer pin input.
// Assumes the pin input is already synchronous to mclk_in.
`timescale 1ns/1ps
module edge_sense (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Sampled level and edge pulses
  input wire logic level_in,
  output logic rise_out,
  output logic fall_out
);
  logic prev;

  // Previous level, one edge per clock is the fastest resolvable rate
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev <= 1'b0;
    end else begin
      prev <= level_in;
    end
  end

  assign rise_out = level_in && !prev;
  assign fall_out = !level_in && prev;
endmodule

// file: hw/down_counter.sv
// Down counter with load, step and wrap to a reload value on underflow.
// Assumes the controller resolves load before step.
`timescale 1ns/1ps
module down_counter #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Control and status toward the timer top
  count_if.cnt cif
);
  logic [WIDTH-1:0] value;
  logic [WIDTH-1:0] next_value;
  wire at_zero = (value == '0);

  assign cif.value = value;
  assign cif.underflow = cif.step && at_zero && !cif.load;
  // A write from the core wins over a step in the same cycle
  assign next_value = cif.load ? cif.load_value :
                      !cif.step ? value :
                      at_zero ? cif.reload_value : value - 1'b1;

  // Count register, all ones after reset
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      value <= WIDTH'(timer_pkg::COUNT_RESET);
    end else begin
      value <= next_value;
    end
  end
endmodule

// file: hw/multimode_timer.sv
// Sixteen-bit multimode down-counting timer with byte-wide register access.
// Assumes a core with byte address, write and read strobes on mclk_in.
// Summary of operation
// - Sixteen-bit down counter, high and low bytes
// - Sixteen-bit reload or capture register, bytes
// - One readable, writable eight-bit control register
// - Reset: count ones, reload zero, control zero
// - Bit four runs or stops timer in PWM and event modes
// - Running counter decrements once per timer clock
// - Mode picks instruction clock or pin edge
// - Underflow reloads; may flag and toggle pin
// - Bit two enables the timer interrupt
// - Bit three is the interrupt pending flag
// - Interrupt from underflow or capture, per mode
// - Capture modes: bit four flags underflow
// - Bit one picks pulse or cycle capture
// - Bits seven to five pick mode; bit zero reserved
// - Timer signal shares port pin two
// - PWM, event count, capture, difference capture
// - PWM: instruction clock, reload, set pending
// - Event count: pin edges, bit five polarity
// - Interrupt needs enable bit and global enable
`timescale 1ns/1ps
module multimode_timer #(
  parameter int COUNT_W = timer_pkg::COUNT_W
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Core register access
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Interrupt toward the core
  input wire logic global_irq_enable_in,
  output logic timer_interrupt_out,
  // Port pin two, shared with the timer signal
  input wire logic port_pin_two_in,
  input wire logic port_pin_two_data_in,
  output logic timer_io_signal_out,
  output logic timer_io_signal_oe_out
);
  typedef enum logic {DIFF_WAIT_START, DIFF_MEASURE} diff_state_t;

  count_if #(.WIDTH(COUNT_W)) cif ();
  logic [7:0] control;
  logic [7:0] next_control;
  logic [COUNT_W-1:0] reload;
  logic [COUNT_W-1:0] next_reload;
  logic pin_level;
  diff_state_t diff_state;
  diff_state_t next_diff_state;
  logic pin_rise;
  logic pin_fall;

  // Pin edge pulses
  edge_sense u_edge (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .level_in(port_pin_two_in),
    .rise_out(pin_rise),
    .fall_out(pin_fall)
  );

  // The count register itself
  down_counter #(.WIDTH(COUNT_W)) u_count (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .cif(cif)
  );

  // Address decode
  wire wr_reload_low = reg_wr_in && (reg_addr_in == timer_pkg::ADDR_RELOAD_LOW);
  wire wr_reload_high = reg_wr_in && (reg_addr_in == timer_pkg::ADDR_RELOAD_HIGH);
  wire wr_count_low = reg_wr_in && (reg_addr_in == timer_pkg::ADDR_COUNT_LOW);
  wire wr_count_high = reg_wr_in && (reg_addr_in == timer_pkg::ADDR_COUNT_HIGH);
  wire wr_control = reg_wr_in && (reg_addr_in == timer_pkg::ADDR_CONTROL);
  wire wr_count = wr_count_low || wr_count_high;
  // Any of the five timer byte addresses; everything else reads as unmapped
  wire addr_mapped = (reg_addr_in >= timer_pkg::ADDR_RELOAD_LOW)
                     && (reg_addr_in <= timer_pkg::ADDR_CONTROL);

  // Mode decode from the two upper select bits
  wire [1:0] mode_bits = {control[timer_pkg::MODE_SELECT_HIGH],
                          control[timer_pkg::MODE_SELECT_MID]};
  wire is_pwm = (mode_bits == timer_pkg::MODE_PWM);
  wire is_event = (mode_bits == timer_pkg::MODE_EVENT);
  wire is_capture = (mode_bits == timer_pkg::MODE_CAPTURE);
  wire is_diff = (mode_bits == timer_pkg::MODE_DIFF);
  wire is_capturing = is_capture || is_diff;
  wire edge_pol = control[timer_pkg::MODE_SELECT_LOW];
  wire pwm_toggle = is_pwm && edge_pol;
  wire run = control[timer_pkg::RUN_BIT];
  wire cycle_type = control[timer_pkg::CAPTURE_TYPE_BIT];

  // Edge selection: polarity bit low picks rising edges as the start edge
  wire start_edge = edge_pol ? pin_fall : pin_rise;
  wire opposite_edge = edge_pol ? pin_rise : pin_fall;

  // Difference capture sequencing
  wire diff_start = is_diff && (diff_state == DIFF_WAIT_START) && start_edge;
  wire diff_end_cycle = is_diff && (diff_state == DIFF_MEASURE) && cycle_type && start_edge;
  wire diff_end_pulse = is_diff && (diff_state == DIFF_MEASURE) && !cycle_type
                        && opposite_edge;
  wire capture_evt = (is_capture && start_edge) || diff_end_cycle || diff_end_pulse;
  wire restart = diff_start || diff_end_cycle;

  // Timer clock: instruction clock or pin edge, per mode
  assign cif.step = is_capturing ? 1'b1 :
                    is_pwm ? run :
                    run && start_edge;
  // Core writes win; a difference restart reloads all ones
  assign cif.load = wr_count || restart;
  assign cif.load_value = wr_count_high ? {reg_wdata_in, cif.value[7:0]} :
                          wr_count_low ? {cif.value[COUNT_W-1:8], reg_wdata_in} :
                          COUNT_W'(timer_pkg::ALL_ONES);
  // Capture modes wrap to all ones, counting modes to the reload register
  assign cif.reload_value = is_capturing ? COUNT_W'(timer_pkg::ALL_ONES) : reload;

  // Flag setting events; hardware sets win over a software clear
  wire count_uf = cif.underflow && !is_capturing;
  wire capture_uf = cif.underflow && is_capturing;
  wire pend_set = count_uf || capture_evt;
  wire [7:0] ctrl_base = wr_control ? {reg_wdata_in[7:1], 1'b0} : control;
  always_comb begin
    next_control = ctrl_base;
    if (pend_set) begin
      next_control[timer_pkg::IRQ_PENDING_FLAG] = 1'b1;
    end
    if (capture_uf) begin
      next_control[timer_pkg::RUN_BIT] = 1'b1;
    end
  end

  // Reload bytes from the core; a capture in the same cycle wins
  assign next_reload = capture_evt ? cif.value :
                       wr_reload_high ? {reg_wdata_in, reload[7:0]} :
                       wr_reload_low ? {reload[COUNT_W-1:8], reg_wdata_in} :
                       reload;

  assign next_diff_state = !is_diff ? DIFF_WAIT_START :
                           diff_start ? DIFF_MEASURE :
                           diff_end_pulse ? DIFF_WAIT_START :
                           diff_state;

  // Control, reload and difference state registers
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      control <= timer_pkg::CONTROL_RESET;
      reload <= COUNT_W'(timer_pkg::RELOAD_RESET);
      diff_state <= DIFF_WAIT_START;
    end else begin
      control <= next_control;
      reload <= next_reload;
      diff_state <= next_diff_state;
    end
  end

  // Pin level: follows the port data until running with toggle, then flips
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_level <= 1'b0;
    end else if (!(pwm_toggle && run)) begin
      pin_level <= port_pin_two_data_in;
    end else if (count_uf) begin
      pin_level <= !pin_level;
    end
  end

  // Pin drive only in PWM with toggle; otherwise the pin is an input
  assign timer_io_signal_out = pin_level;
  assign timer_io_signal_oe_out = pwm_toggle;

  // Interrupt: enable bit, global enable, and a pending flag of the mode
  wire any_pending = control[timer_pkg::IRQ_PENDING_FLAG] || (is_capturing && run);
  assign timer_interrupt_out = control[timer_pkg::IRQ_ENABLE_BIT] && global_irq_enable_in
                               && any_pending;

  // Read mux, registered on the read strobe
  wire [7:0] read_mux = (reg_addr_in == timer_pkg::ADDR_RELOAD_LOW) ? reload[7:0] :
                        (reg_addr_in == timer_pkg::ADDR_RELOAD_HIGH) ? reload[COUNT_W-1:8] :
                        (reg_addr_in == timer_pkg::ADDR_COUNT_LOW) ? cif.value[7:0] :
                        (reg_addr_in == timer_pkg::ADDR_COUNT_HIGH) ? cif.value[COUNT_W-1:8] :
                        (reg_addr_in == timer_pkg::ADDR_CONTROL) ? control :
                        timer_pkg::READ_UNMAPPED;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= read_mux;
    end
  end

  // Checks on the behaviour above
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_diff_start;
    is_diff && !cycle_type && diff_start && !reg_wr_in;
  endsequence
  sequence s_diff_measured;
    (diff_state == DIFF_MEASURE) && (cif.value == COUNT_W'(timer_pkg::ALL_ONES));
  endsequence
  // End of a measurement, like-edge and opposite-edge variants
  sequence s_diff_cycle_end;
    is_diff && cycle_type && (diff_state == DIFF_MEASURE) && start_edge && !reg_wr_in;
  endsequence
  sequence s_diff_pulse_end;
    is_diff && !cycle_type && (diff_state == DIFF_MEASURE) && opposite_edge && !reg_wr_in;
  endsequence

  a_pwm_reload: assert property (
    is_pwm && run && cif.value == '0 && !reg_wr_in |=> cif.value == $past(reload)
      && control[timer_pkg::IRQ_PENDING_FLAG])
    else $error("PWM underflow did not reload and flag");
  a_count_decrement: assert property (
    is_pwm && run && cif.value != '0 && !reg_wr_in
      |=> cif.value == COUNT_W'($past(cif.value) - 1'b1))
    else $error("running counter did not decrement by one");
  a_stopped_hold: assert property (
    (is_pwm || is_event) && !run && !reg_wr_in |=> $stable(cif.value))
    else $error("stopped counter moved");
  a_event_edge: assert property (
    is_event && run && !start_edge && !reg_wr_in |=> $stable(cif.value))
    else $error("event counter moved without its edge");
  a_capture_copy: assert property (
    is_capture && start_edge && !reg_wr_in
      |=> reload == $past(cif.value) && control[timer_pkg::IRQ_PENDING_FLAG])
    else $error("capture edge did not copy count");
  a_capture_uf_flag: assert property (
    is_capturing && cif.value == '0 && !reg_wr_in
      |=> control[timer_pkg::RUN_BIT] && cif.value == COUNT_W'(timer_pkg::ALL_ONES))
    else $error("capture underflow not flagged");
  a_pin_toggle: assert property (
    pwm_toggle && run && cif.underflow && !reg_wr_in
      |=> timer_io_signal_out != $past(timer_io_signal_out))
    else $error("PWM underflow did not toggle the pin");
  a_irq_gate: assert property (
    !(control[timer_pkg::IRQ_ENABLE_BIT] && global_irq_enable_in) |-> !timer_interrupt_out)
    else $error("interrupt raised while masked");
  a_irq_raise: assert property (
    control[timer_pkg::IRQ_ENABLE_BIT] && global_irq_enable_in
      && control[timer_pkg::IRQ_PENDING_FLAG] |-> timer_interrupt_out)
    else $error("pending interrupt not raised");
  a_reserved_zero: assert property (
    control[timer_pkg::RESERVED_BIT] == 1'b0)
    else $error("reserved control bit set");
  a_diff_restart: assert property (
    s_diff_start |=> s_diff_measured)
    else $error("difference start edge did not restart the count");
  a_unmapped_read: assert property (
    reg_rd_in && !addr_mapped |=> reg_rdata_out == timer_pkg::READ_UNMAPPED)
    else $error("unmapped read returned data");
  a_diff_cycle_end: assert property (
    s_diff_cycle_end |=> reload == $past(cif.value) && control[timer_pkg::IRQ_PENDING_FLAG]
      && cif.value == COUNT_W'(timer_pkg::ALL_ONES))
    else $error("cycle capture end did not capture and restart");
  a_diff_pulse_end: assert property (
    s_diff_pulse_end |=> reload == $past(cif.value) && diff_state == DIFF_WAIT_START
      && control[timer_pkg::IRQ_PENDING_FLAG])
    else $error("pulse capture end did not capture");
  a_event_step: assert property (
    is_event && run && start_edge && cif.value != '0 && !reg_wr_in
      |=> cif.value == COUNT_W'($past(cif.value) - 1'b1))
    else $error("event edge did not step the counter");
  // The pin output must track the port data whenever the timer does not own it
  a_pin_follow: assert property (
    !(pwm_toggle && run) |=> timer_io_signal_out == $past(port_pin_two_data_in))
    else $error("idle pin output did not follow port data");
  a_capture_irq: assert property (
    control[timer_pkg::IRQ_ENABLE_BIT] && global_irq_enable_in && is_capturing && run
      |-> timer_interrupt_out)
    else $error("capture underflow interrupt not raised");
  a_read_hold: assert property (
    !reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data changed without a read strobe");
  a_pend_hold: assert property (
    control[timer_pkg::IRQ_PENDING_FLAG] && !wr_control |=> control[timer_pkg::IRQ_PENDING_FLAG])
    else $error("pending flag cleared without a write");
  // A clear racing a new event must not lose the event
  a_set_wins: assert property (
    wr_control && !reg_wdata_in[timer_pkg::IRQ_PENDING_FLAG] && pend_set
      |=> control[timer_pkg::IRQ_PENDING_FLAG])
    else $error("software clear beat a hardware set");
  a_count_write: assert property (
    wr_count_low |=> cif.value[7:0] == $past(reg_wdata_in))
    else $error("count low byte write lost");
  a_reload_write: assert property (
    wr_reload_high && !capture_evt |=> reload[COUNT_W-1:8] == $past(reg_wdata_in))
    else $error("reload high byte write lost");
  a_ctrl_write: assert property (
    wr_control && !pend_set && !capture_uf
      |=> control == {$past(reg_wdata_in[7:1]), 1'b0})
    else $error("control write not stored");
endmodule

// file: test/pin_source.sv
// Partner model: an external device that drives the timer pin with pulses.
// Assumes the pin level is sampled on mclk_in; the level changes on falling edges.
`timescale 1ns/1ps
module pin_source (
  // Clock
  input wire logic mclk_in,
  // Level seen on port pin two
  output logic pin_out
);
  initial pin_out = 1'b0;
  // One pulse: high for hi cycles, then low for lo cycles
  // Pulses of one cycle are still resolved by the edge detector; callers keep both at two or more
  task automatic pulse(input int hi, input int lo);
    @(negedge mclk_in);
    pin_out = 1'b1;
    repeat (hi) @(negedge mclk_in);
    pin_out = 1'b0;
    repeat (lo - 1) @(negedge mclk_in);
  endtask
endmodule

// file: test/tb.sv
// Self-checking bench for the multimode timer: registers, modes, pin and interrupt.
// Assumes the register map and control bits of timer_pkg.
`timescale 1ns/1ps
module tb;
  logic mclk_in, rst_n_in, wr, rd, glb, pdata, irq, pin_o, pin_oe, pin_i;
  logic [7:0] addr, wdata, rdata, q;
  int err_total, checked;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  // Write then read back; control bit 0 reads zero, unmapped reads zero
  row_t rows [6] = '{'{8'hAA, 8'h5A, 8'h5A}, '{8'hAB, 8'hA5, 8'hA5},
    '{8'hAC, 8'h3C, 8'h3C}, '{8'hAD, 8'hC3, 8'hC3}, '{8'hAE, 8'h07, 8'h06},
    '{8'hB0, 8'hFF, 8'h00}};
  multimode_timer u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .global_irq_enable_in(glb), .timer_interrupt_out(irq), .port_pin_two_in(pin_i),
    .port_pin_two_data_in(pdata), .timer_io_signal_out(pin_o),
    .timer_io_signal_oe_out(pin_oe));
  pin_source u_pin (.mclk_in(mclk_in), .pin_out(pin_i));
  // Clock at 4 ns
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  task automatic end_sim;
    if (err_total == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  // One byte access; strobe held across exactly one rising edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    addr = a;
    wdata = d;
    wr = w;
    rd = !w;
    @(negedge mclk_in);
    wr = 1'b0;
    rd = 1'b0;
    q = rdata;
  endtask
  task automatic wrb(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk8(q, e);
  endtask
  // Bounded wait for the interrupt line
  task automatic wait_irq;
    int i;
    for (i = 0; i < 64 && irq !== 1'b1; i++) @(negedge mclk_in);
    if (irq !== 1'b1) begin
      chk1(irq, 1'b1);
      end_sim();
    end
  endtask
  initial begin
    rst_n_in = 1'b0;
    {wr, rd, glb} = 3'h0;
    pdata = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    err_total = 0;
    checked = 0;
    repeat (4) @(negedge mclk_in);
    rst_n_in = 1'b1;
    foreach (rows[i]) begin
      wrb(rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].e);
    end
    // Second reset in mid-run restores every register
    rst_n_in = 1'b0;
    repeat (4) @(negedge mclk_in);
    rst_n_in = 1'b1;
    for (int i = 0; i < 5; i++) rdc(8'(8'hAA + i), (i == 2 || i == 3) ? 8'hFF : 8'h00);
    // PWM with toggle: count 2, reload 0x0100, interrupt enabled
    wrb(8'hAA, 8'h00);
    wrb(8'hAB, 8'h01);
    wrb(8'hAD, 8'h00);
    wrb(8'hAC, 8'h02);
    chk1(pin_o, 1'b1);
    glb = 1'b1;
    wrb(8'hAE, 8'hB4);
    wait_irq();
    chk1(pin_o, 1'b0);
    chk1(pin_oe, 1'b1);
    glb = 1'b0;
    #1 chk1(irq, 1'b0);
    rdc(8'hAE, 8'hBC);
    wrb(8'hAE, 8'hA0);
    rdc(8'hAE, 8'hA0);
    acc(1'b0, 8'hAC, 8'h00);
    rdc(8'hAC, q);
    chk1(pin_o, 1'b1);
    // Event counting, rising then falling edges
    wrb(8'hAD, 8'h00);
    wrb(8'hAC, 8'h02);
    wrb(8'hAE, 8'h10);
    repeat (2) u_pin.pulse(2, 2);
    rdc(8'hAC, 8'h00);
    chk1(pin_oe, 1'b0);
    wrb(8'hAE, 8'h34);
    glb = 1'b1;
    u_pin.pulse(2, 2);
    rdc(8'hAD, 8'h01);
    rdc(8'hAE, 8'h3C);
    chk1(irq, 1'b1);
    wrb(8'hAE, 8'h38);
    chk1(irq, 1'b0);
    // Standard capture on a rising edge while counting from 0x8000
    wrb(8'hAD, 8'h80);
    wrb(8'hAC, 8'h00);
    wrb(8'hAE, 8'h40);
    repeat (6) @(negedge mclk_in);
    u_pin.pulse(2, 2);
    rdc(8'hAB, 8'h7F);
    rdc(8'hAE, 8'h48);
    // Difference capture, rising start and falling end
    wrb(8'hAE, 8'hC0);
    u_pin.pulse(10, 2);
    rdc(8'hAB, 8'hFF);
    rdc(8'hAE, 8'hC8);
    // Difference capture, falling start, cycle type: eight ticks between falls
    wrb(8'hAE, 8'hE2);
    repeat (2) u_pin.pulse(3, 5);
    rdc(8'hAA, 8'hF8);
    rdc(8'hAB, 8'hFF);
    rdc(8'hAE, 8'hEA);
    // Capture underflow sets bit four and, enabled, interrupts the core
    wrb(8'hAE, 8'h44);
    wrb(8'hAC, 8'h08);
    wrb(8'hAD, 8'h00);
    wait_irq();
    rdc(8'hAE, 8'h54);
    rdc(8'hAD, 8'hFF);
    chk1(irq, 1'b1);
    end_sim();
  end
endmodule
